/* hdl/pcicr_regs.sv */
`default_nettype none

// Overview of operation
// - Capability pointer reads fixed first entry offset.
// - Interrupt pin bits seven to one read zero.
// - Pin bit zero set by preload or local bus.
// - Pin bit one means single interrupt used.
// - Wake mask preloadable, bits 4,2,1 stay zero.
// - Intermediate state support bits read zero.
// - Auxiliary power source bit reads zero.
// - Version resets to one, overridable locally.
// - Next capability offset reads hot-swap entry.
// - Capability identifier reads power management code.
// - Local fields ignore host writes, block during load.
// - Preload accepted only when strap latched high.

// ============================================================
// Capability pointer, miscellaneous and power capability registers.
// ============================================================
module pcicr_regs (
    input  wire logic        core_clk,     // System clock, 40 MHz.
    input  wire logic        rst,          // Bus reset, asynchronous, active high.
    input  wire logic        eeprom_present_strap, // Preload strap level.
    input  wire logic        cfg_req,      // Host configuration access strobe.
    input  wire logic        cfg_wr,       // Host access is a write.
    input  wire logic [7:0]  cfg_addr,     // Host byte offset of the dword.
    input  wire logic [3:0]  cfg_be,       // Host byte enables.
    input  wire logic [31:0] cfg_wdata,    // Host write data.
    output logic      [31:0] cfg_rdata,    // Host read data.
    output logic             cfg_ack,      // Host access done.
    input  wire logic        lb_req,       // Local bus access strobe.
    input  wire logic        lb_wr,        // Local access is a write.
    input  wire logic [7:0]  lb_addr,      // Local byte offset of the dword.
    input  wire logic [3:0]  lb_be,        // Local byte enables.
    input  wire logic [31:0] lb_wdata,     // Local write data.
    output logic      [31:0] lb_rdata,     // Local read data.
    output logic             lb_ack,       // Local access done.
    input  wire logic        ee_busy,      // Preload in progress.
    input  wire logic        ee_wr,        // Preload word strobe.
    input  wire logic [7:0]  ee_addr,      // Preload byte offset.
    input  wire logic [3:0]  ee_be,        // Preload byte enables.
    input  wire logic [31:0] ee_wdata,     // Preload data.
    output logic             uses_pci_interrupt, // Device drives one interrupt.
    output logic      [7:0]  interrupt_line, // Routing byte set by host.
    output logic      [4:0]  wake_support  // Power states that may raise wake.
);

    // ============================================================
    // Helpers.
    // ============================================================

    // Dword match of a byte offset against a register offset.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction : hit

    // Byte lane merge of write data into an old byte.
    function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] be, input int lsb);
        lane = be[lsb/8] ? d[lsb +: 8] : old;
    endfunction : lane

    // ============================================================
    // State.
    // ============================================================
    logic [7:0] latency_reg,   latency_next;   // Maximum latency byte.
    logic [7:0] min_gnt_reg,   min_gnt_next;   // Minimum grant byte.
    logic       int_pin_reg,   int_pin_next;   // Interrupt pin bit zero.
    logic [7:0] int_line_reg,  int_line_next;  // Interrupt line byte.
    logic [4:0] wake_reg,      wake_next;      // Wake support mask.
    logic       dsi_reg,       dsi_next;       // Device specific initialisation.
    logic [2:0] ver_reg,       ver_next;       // Power management version.
    logic       strap_reg,     strap_next;     // Latched preload strap.
    logic       strap_done_reg, strap_done_next; // Strap has been sampled.
    logic [31:0] cfg_rdata_next;               // Next host read data.
    logic [31:0] lb_rdata_next;                // Next local read data.

    // Qualified writers.
    logic lb_ok;   // Local write allowed.
    logic ee_ok;   // Preload write allowed.
    logic cfg_ok;  // Host write.

    // A local write racing a preload would leave a half loaded field.
    assign lb_ok  = lb_req && lb_wr && !ee_busy;
    assign ee_ok  = ee_wr && ee_busy && strap_reg;
    assign cfg_ok = cfg_req && cfg_wr;

    // Read image of a register; unmapped offsets read zero.
    function automatic logic [31:0] image(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (hit(a, pcicr_pkg::CAP_PTR_OFF)) begin
            w[7:0] = pcicr_pkg::FIRST_CAP;
        end else if (hit(a, pcicr_pkg::MISC_OFF)) begin
            w[pcicr_pkg::LATENCY_LSB +: 8]  = latency_reg;
            w[pcicr_pkg::MIN_GNT_LSB +: 8]  = min_gnt_reg;
            w[pcicr_pkg::INT_PIN_LSB]       = int_pin_reg;
            w[pcicr_pkg::INT_LINE_LSB +: 8] = int_line_reg;
        end else if (hit(a, pcicr_pkg::PMC_OFF)) begin
            w[pcicr_pkg::WAKE_LSB +: 5]     = wake_reg;
            w[pcicr_pkg::STATE_TWO]         = 1'b0;
            w[pcicr_pkg::STATE_ONE]         = 1'b0;
            w[pcicr_pkg::DSI_BIT]           = dsi_reg;
            w[pcicr_pkg::AUX_PWR_BIT]       = 1'b0;
            w[pcicr_pkg::WAKE_CLK_BIT]      = |wake_reg;
            w[pcicr_pkg::VER_LSB +: 3]      = ver_reg;
            w[pcicr_pkg::NEXT_LSB +: 8]     = pcicr_pkg::NEXT_CAP;
            w[pcicr_pkg::ID_LSB +: 8]       = pcicr_pkg::PM_CAP_CODE;
        end
        image = w;
    endfunction : image

    // ============================================================
    // Strap capture.
    // ============================================================

    // The strap is caught on the first edge after reset release, since
    // an asynchronously reset flop may not load a port value.
    always_comb begin
        strap_next      = strap_reg;
        strap_done_next = 1'b1;
        if (!strap_done_reg) begin
            strap_next = eeprom_present_strap;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_reg      <= 1'b0;
            strap_done_reg <= 1'b0;
        end else begin
            strap_reg      <= strap_next;
            strap_done_reg <= strap_done_next;
        end
    end

    // ============================================================
    // Field updates.
    // ============================================================

    // Preload and local writes never coincide, since local writes are
    // held off for the whole load. Host writes only reach the line byte.
    always_comb begin
        latency_next  = latency_reg;
        min_gnt_next  = min_gnt_reg;
        int_pin_next  = int_pin_reg;
        int_line_next = int_line_reg;
        wake_next     = wake_reg;
        dsi_next      = dsi_reg;
        ver_next      = ver_reg;
        // The host may set the line byte; a local write in the same
        // cycle comes later and wins.
        if (cfg_ok && hit(cfg_addr, pcicr_pkg::MISC_OFF)) begin
            int_line_next = lane(int_line_reg, cfg_wdata, cfg_be,
                                 pcicr_pkg::INT_LINE_LSB);
        end
        if (lb_ok && hit(lb_addr, pcicr_pkg::MISC_OFF)) begin
            latency_next  = lane(latency_reg, lb_wdata, lb_be, pcicr_pkg::LATENCY_LSB);
            min_gnt_next  = lane(min_gnt_reg, lb_wdata, lb_be, pcicr_pkg::MIN_GNT_LSB);
            int_line_next = lane(int_line_reg, lb_wdata, lb_be, pcicr_pkg::INT_LINE_LSB);
            if (lb_be[1]) begin
                int_pin_next = lb_wdata[pcicr_pkg::INT_PIN_LSB];
            end
        end else if (ee_ok && hit(ee_addr, pcicr_pkg::MISC_OFF)) begin
            latency_next = lane(latency_reg, ee_wdata, ee_be, pcicr_pkg::LATENCY_LSB);
            min_gnt_next = lane(min_gnt_reg, ee_wdata, ee_be, pcicr_pkg::MIN_GNT_LSB);
            if (ee_be[1]) begin
                int_pin_next = ee_wdata[pcicr_pkg::INT_PIN_LSB];
            end
        end
        // Power management fields: local bus first, else preload.
        if (lb_ok && hit(lb_addr, pcicr_pkg::PMC_OFF)) begin
            if (lb_be[3]) begin
                wake_next = lb_wdata[pcicr_pkg::WAKE_LSB +: 5]
                            & pcicr_pkg::WAKE_WR_MASK;
            end
            if (lb_be[2]) begin
                dsi_next = lb_wdata[pcicr_pkg::DSI_BIT];
                ver_next = lb_wdata[pcicr_pkg::VER_LSB +: 3];
            end
        end else if (ee_ok && hit(ee_addr, pcicr_pkg::PMC_OFF)) begin
            if (ee_be[3]) begin
                wake_next = ee_wdata[pcicr_pkg::WAKE_LSB +: 5]
                            & pcicr_pkg::WAKE_WR_MASK;
            end
            if (ee_be[2]) begin
                dsi_next = ee_wdata[pcicr_pkg::DSI_BIT];
                ver_next = ee_wdata[pcicr_pkg::VER_LSB +: 3];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            latency_reg  <= pcicr_pkg::BYTE_RST;
            min_gnt_reg  <= pcicr_pkg::BYTE_RST;
            int_pin_reg  <= 1'b0;
            int_line_reg <= pcicr_pkg::BYTE_RST;
            wake_reg     <= pcicr_pkg::WAKE_RST;
            dsi_reg      <= 1'b0;
            ver_reg      <= pcicr_pkg::PM_REV_RST;
        end else begin
            latency_reg  <= latency_next;
            min_gnt_reg  <= min_gnt_next;
            int_pin_reg  <= int_pin_next;
            int_line_reg <= int_line_next;
            wake_reg     <= wake_next;
            dsi_reg      <= dsi_next;
            ver_reg      <= ver_next;
        end
    end

    // ============================================================
    // Read answers and status outputs.
    // ============================================================

    // Every access is answered one cycle later; writes return zero data.
    always_comb begin
        cfg_rdata_next = (cfg_req && !cfg_wr) ? image(cfg_addr) : 32'h0000_0000;
        lb_rdata_next  = (lb_req && !lb_wr) ? image(lb_addr) : 32'h0000_0000;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_rdata          <= 32'h0000_0000;
            cfg_ack            <= 1'b0;
            lb_rdata           <= 32'h0000_0000;
            lb_ack             <= 1'b0;
            uses_pci_interrupt <= 1'b0;
            interrupt_line     <= pcicr_pkg::BYTE_RST;
            wake_support       <= pcicr_pkg::WAKE_RST;
        end else begin
            cfg_rdata          <= cfg_rdata_next;
            cfg_ack            <= cfg_req;
            lb_rdata           <= lb_rdata_next;
            lb_ack             <= lb_req;
            uses_pci_interrupt <= int_pin_next;
            interrupt_line     <= int_line_next;
            wake_support       <= wake_next;
        end
    end

    // ============================================================
    // Checks.
    // ============================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Host read of a given dword.
    sequence s_host_read(logic [7:0] off);
        cfg_req && !cfg_wr && hit(cfg_addr, off);
    endsequence

    property p_cap_ptr;
        s_host_read(pcicr_pkg::CAP_PTR_OFF) |=> cfg_ack && cfg_rdata == 32'h0000_00DC;
    endproperty
    a_cap_ptr: assert property (p_cap_ptr) else $error("pointer word wrong");

    property p_pin_upper;
        s_host_read(pcicr_pkg::MISC_OFF) |=> cfg_rdata[15:9] == 7'h00;
    endproperty
    a_pin_upper: assert property (p_pin_upper) else $error("pin upper bits set");

    property p_pin_write;
        lb_ok && hit(lb_addr, pcicr_pkg::MISC_OFF) && lb_be[1]
            |=> int_pin_reg == $past(lb_wdata[8]) ##1 uses_pci_interrupt == int_pin_reg;
    endproperty
    a_pin_write: assert property (p_pin_write) else $error("pin bit not taken");

    // The flag seen by the interrupt logic must agree with what the host reads back,
    // unless the pin bit is being rewritten in the same cycle.
    property p_uses_int;
        s_host_read(pcicr_pkg::MISC_OFF) && int_pin_next == int_pin_reg
            |=> cfg_rdata[8] == uses_pci_interrupt;
    endproperty
    a_uses_int: assert property (p_uses_int) else $error("interrupt use flag stale");

    property p_wake_zero;
        wake_reg[4] == 1'b0 && wake_reg[2:1] == 2'b00;
    endproperty
    a_wake_zero: assert property (p_wake_zero) else $error("illegal wake bit");

    property p_pmc_fixed;
        s_host_read(pcicr_pkg::PMC_OFF) |=> cfg_rdata[26:25] == 2'b00
            && !cfg_rdata[20] && cfg_rdata[24:22] == 3'h0 && cfg_rdata[15:0] == 16'hE401;
    endproperty
    a_pmc_fixed: assert property (p_pmc_fixed) else $error("fixed pm bits wrong");

    property p_wake_clk;
        s_host_read(pcicr_pkg::PMC_OFF) |=> cfg_rdata[19] == |cfg_rdata[31:27];
    endproperty
    a_wake_clk: assert property (p_wake_clk) else $error("wake clock bit wrong");

    property p_host_ignored;
        cfg_ok && !lb_ok && !ee_ok |=> $stable(latency_reg) && $stable(min_gnt_reg)
            && $stable(int_pin_reg) && $stable(ver_reg) && $stable(wake_reg);
    endproperty
    a_host_ignored: assert property (p_host_ignored) else $error("host wrote local field");

    property p_no_strap;
        !strap_reg && !lb_ok |=> $stable(latency_reg) && $stable(ver_reg);
    endproperty
    a_no_strap: assert property (p_no_strap) else $error("preload without strap");

endmodule : pcicr_regs

`default_nettype wire

/* hdl/pcicr_pkg.sv */
`default_nettype none

// ============================================================
// Configuration header constants for the capability registers.
// ============================================================
package pcicr_pkg;

    // Dword byte offsets of the three registers in configuration space.
    localparam logic [7:0] CAP_PTR_OFF  = 8'h34; // Capability list pointer.
    localparam logic [7:0] MISC_OFF     = 8'h3C; // Latency, grant and interrupt.
    localparam logic [7:0] PMC_OFF      = 8'hDC; // Power management capabilities.

    // Fixed values seen by the host.
    localparam logic [7:0] FIRST_CAP    = 8'hDC; // Offset of the first capability entry.
    localparam logic [7:0] NEXT_CAP     = 8'hE4; // Offset of the hot-swap entry.
    localparam logic [7:0] PM_CAP_CODE  = 8'h01; // Power management capability code.

    // Reset values.
    localparam logic [2:0] PM_REV_RST   = 3'h1;  // Interface revision code.
    localparam logic [4:0] WAKE_RST     = 5'h00; // No wake support after reset.
    localparam logic [7:0] BYTE_RST     = 8'h00; // Plain byte fields.

    // Only bits 3 and 0 of the wake support mask can ever be set.
    localparam logic [4:0] WAKE_WR_MASK = 5'h09;

    // Field positions of the miscellaneous register.
    localparam int LATENCY_LSB  = 24; // Maximum latency byte.
    localparam int MIN_GNT_LSB  = 16; // Minimum grant byte.
    localparam int INT_PIN_LSB  = 8;  // Interrupt pin byte.
    localparam int INT_LINE_LSB = 0;  // Interrupt line byte.

    // Field positions of the power management capabilities register.
    localparam int WAKE_LSB     = 27; // Wake support mask, five bits.
    localparam int STATE_TWO    = 26; // Intermediate state two support.
    localparam int STATE_ONE    = 25; // Intermediate state one support.
    localparam int DSI_BIT      = 21; // Device specific initialisation.
    localparam int AUX_PWR_BIT  = 20; // Auxiliary power source.
    localparam int WAKE_CLK_BIT = 19; // Clock needed for wake signalling.
    localparam int VER_LSB      = 16; // Version, three bits.
    localparam int NEXT_LSB     = 8;  // Next capability offset.
    localparam int ID_LSB       = 0;  // Capability identifier.

endpackage : pcicr_pkg

`default_nettype wire

/* verif/pcicr_host_model.sv */
`default_nettype none

// ============================================================
// Host side: issues configuration cycles one at a time.
// ============================================================
module pcicr_host_model (
    input  wire logic        core_clk,  // Bus clock.
    output logic             cfg_req,   // Access strobe.
    output logic             cfg_wr,    // Write when high.
    output logic      [7:0]  cfg_addr,  // Dword byte offset.
    output logic      [3:0]  cfg_be,    // Byte enables.
    output logic      [31:0] cfg_wdata, // Write data.
    input  wire logic [31:0] cfg_rdata, // Read data.
    input  wire logic        cfg_ack    // Access done.
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus is idle and defined from time zero.
    initial begin
        cfg_req   = 1'h0;
        cfg_wr    = 1'h0;
        cfg_addr  = 8'h00;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0;
    end

    // One access: the strobe lasts one edge, qualifiers stay until the answer edge.
    // Released address, enable and data lines then show the inverse of their last value, so a design that
    // samples them outside an access cannot pass by reading stale data.
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        @(posedge core_clk);
        cfg_req   <= 1'h1;
        cfg_wr    <= wr;
        cfg_addr  <= a;
        cfg_be    <= be;
        cfg_wdata <= wd;
        @(posedge core_clk);
        cfg_req   <= 1'h0;
        @(posedge core_clk);
        ok = (cfg_ack === 1'h1);
        rd = cfg_rdata;
        cfg_addr  <= ~a;
        cfg_be    <= ~be;
        cfg_wdata <= ~wd;
    endtask : access
endmodule : pcicr_host_model

`default_nettype wire

/* verif/pci_config_capability_regs_tb.sv */
`default_nettype none

// ============================================================
// Self-checking bench for the capability register bank.
// ============================================================
module pci_config_capability_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic        via; // High for a local bus access.
        logic        wr;  // High for a write.
        logic [7:0]  a;   // Dword offset.
        logic [3:0]  be;  // Byte enables.
        logic [31:0] wd;  // Write data.
        logic [31:0] exp; // Expected read data, zero for writes.
    } pcicr_row_s;

    // Ordinary cases run in this order, each row building on the last.
    localparam pcicr_row_s ROWS [19] = '{
        '{1'h0, 1'h0, 8'h34, 4'hF, 32'h0, 32'h000000DC},
        '{1'h0, 1'h0, 8'h3C, 4'hF, 32'h0, 32'h00000000},
        '{1'h0, 1'h0, 8'hDC, 4'hF, 32'h0, 32'h0001E401},
        '{1'h0, 1'h0, 8'h40, 4'hF, 32'h0, 32'h00000000},
        '{1'h0, 1'h1, 8'h3C, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 1'h0, 8'h3C, 4'hF, 32'h0, 32'h000000FF},
        '{1'h0, 1'h1, 8'h34, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 1'h0, 8'h34, 4'hF, 32'h0, 32'h000000DC},
        '{1'h0, 1'h1, 8'hDC, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 1'h0, 8'hDC, 4'hF, 32'h0, 32'h0001E401},
        '{1'h1, 1'h1, 8'h3C, 4'hF, 32'hABCD0112, 32'h0},
        '{1'h0, 1'h0, 8'h3C, 4'hF, 32'h0, 32'hABCD0112},
        '{1'h1, 1'h1, 8'h3C, 4'h2, 32'h0000FE00, 32'h0},
        '{1'h1, 1'h0, 8'h3C, 4'hF, 32'h0, 32'hABCD0012},
        '{1'h1, 1'h1, 8'hDC, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 1'h0, 8'hDC, 4'hF, 32'h0, 32'h482FE401},
        '{1'h1, 1'h1, 8'hDC, 4'h8, 32'h90000000, 32'h0},
        '{1'h0, 1'h0, 8'hDC, 4'hF, 32'h0, 32'h0027E401},
        '{1'h1, 1'h1, 8'hDC, 4'h8, 32'h08000000, 32'h0}
    };
    localparam int LIMIT = 3000; // Cycles; the run needs well under a thousand.

    logic        core_clk;             // Clock, 25 ns period.
    logic        rst;                  // Reset, active high.
    logic        eeprom_present_strap; // Preload strap.
    logic        cfg_req, cfg_wr, cfg_ack, lb_req, lb_wr, lb_ack;
    logic [7:0]  cfg_addr, lb_addr, ee_addr, interrupt_line;
    logic [3:0]  cfg_be, lb_be, ee_be;
    logic [31:0] cfg_wdata, cfg_rdata, lb_wdata, lb_rdata, ee_wdata;
    logic        ee_busy, ee_wr, uses_pci_interrupt;
    logic [4:0]  wake_support;
    logic [31:0] rd;                   // Last read data.
    logic        ok;                   // Last answer seen in time.
    int          n_fail, n_tests, cycles;

    pcicr_regs u_dut (.core_clk(core_clk), .rst(rst),
        .eeprom_present_strap(eeprom_present_strap), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .lb_req(lb_req), .lb_wr(lb_wr), .lb_addr(lb_addr), .lb_be(lb_be),
        .lb_wdata(lb_wdata), .lb_rdata(lb_rdata), .lb_ack(lb_ack), .ee_busy(ee_busy),
        .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_be(ee_be), .ee_wdata(ee_wdata),
        .uses_pci_interrupt(uses_pci_interrupt), .interrupt_line(interrupt_line),
        .wake_support(wake_support));

    pcicr_host_model u_host (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

    // Free-running clock.
    always #12.5 core_clk = ~core_clk;

    // Every comparison is counted; a mismatch is reported at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Local bus access, same timing as the host port.
    task automatic lb_access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                             input logic [31:0] wd);
        @(posedge core_clk);
        lb_req   <= 1'h1;
        lb_wr    <= wr;
        lb_addr  <= a;
        lb_be    <= be;
        lb_wdata <= wd;
        @(posedge core_clk);
        lb_req   <= 1'h0;
        @(posedge core_clk);
        ok = (lb_ack === 1'h1);
        rd = lb_rdata;
        lb_wdata <= ~wd;
    endtask : lb_access

    // One preload word; the loader holds busy around these itself.
    task automatic ee_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
        @(posedge core_clk);
        ee_wr    <= 1'h1;
        ee_addr  <= a;
        ee_be    <= be;
        ee_wdata <= wd;
        @(posedge core_clk);
        ee_wr    <= 1'h0;
        ee_wdata <= ~wd;
    endtask : ee_write

    // Access by either port, then check the answer and its data.
    task automatic access(input pcicr_row_s r);
        if (r.via) begin
            lb_access(r.wr, r.a, r.be, r.wd);
        end else begin
            u_host.access(r.wr, r.a, r.be, r.wd, rd, ok);
        end
        chk({31'h0, ok}, 32'h1);
        chk(rd, r.exp);
    endtask : access

    // Reset for two cycles with the given strap; the strap is latched on release.
    task automatic do_reset(input logic strap);
        eeprom_present_strap <= strap;
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        chk({23'h0, uses_pci_interrupt, interrupt_line}, 32'h0);
        chk({27'h0, wake_support}, 32'h0);
    endtask : do_reset

    // The single place where the run ends.
    task automatic summarize();
        $display("tests=%0d failures=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // A hang counts as a mismatch and still reaches the report.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        {core_clk, rst, eeprom_present_strap, lb_req, lb_wr, ee_busy, ee_wr} = '0;
        {lb_addr, lb_be, lb_wdata, ee_addr, ee_be, ee_wdata} = '0;
        {n_fail, n_tests, cycles} = '0;
        do_reset(1'h0);
        foreach (ROWS[i]) begin
            access(ROWS[i]);
        end
        chk({27'h0, wake_support}, 32'h01);
        chk({31'h0, uses_pci_interrupt}, 32'h0);
        chk({24'h0, interrupt_line}, 32'h12);
        // Without the strap a preload word must change nothing.
        ee_busy <= 1'h1;
        ee_write(8'h3C, 4'h8, 32'h55000000);
        ee_busy <= 1'h0;
        access('{1'h0, 1'h0, 8'h3C, 4'hF, 32'h0, 32'hABCD0012});
        // Second reset mid-run, strap high, local write racing the preload.
        do_reset(1'h1);
        access('{1'h0, 1'h0, 8'hDC, 4'hF, 32'h0, 32'h0001E401});
        ee_busy <= 1'h1;
        access('{1'h1, 1'h1, 8'h3C, 4'h8, 32'h77000000, 32'h0});
        ee_write(8'hDC, 4'hC, 32'h08020000);
        ee_write(8'h3C, 4'h2, 32'h00000100);
        ee_busy <= 1'h0;
        access('{1'h0, 1'h0, 8'h3C, 4'hF, 32'h0, 32'h00000100});
        access('{1'h0, 1'h0, 8'hDC, 4'hF, 32'h0, 32'h080AE401});
        chk({31'h0, uses_pci_interrupt}, 32'h1);
        chk({27'h0, wake_support}, 32'h01);
        access('{1'h1, 1'h1, 8'h3C, 4'h8, 32'h77000000, 32'h0});
        access('{1'h0, 1'h0, 8'h3C, 4'hF, 32'h0, 32'h77000100});
        summarize();
    end
endmodule : pci_config_capability_regs_tb

`default_nettype wire
